//--- pkg/adcsq_pkg.sv
`default_nettype none
package adcsq_pkg;

  // ==========================================================
  // register offsets on the 8-bit internal bus
  localparam logic [3:0] OFS_RES_LAST = 4'h7;
  localparam logic [3:0] OFS_CSR = 4'h8;
  localparam logic [3:0] OFS_TCR = 4'h9;
  localparam int OFS_IDX_HI = 2;
  localparam int OFS_IDX_LO = 1;
  localparam int OFS_BYTE_LO = 0;

  // ==========================================================
  // field positions and reset values
  localparam int CSR_FLAG = 7;
  localparam int CSR_IE = 6;
  localparam int CSR_START = 5;
  localparam int CSR_SCAN = 4;
  localparam int CSR_CKS = 3;
  localparam int CSR_GRP = 2;
  localparam int TCR_TE = 7;
  localparam int TCR_RSV = 0;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] TCR_RESET = 8'h7f;
  localparam logic [7:0] TCR_ONES = 8'h7e;
  localparam logic [5:0] RES_PAD = 6'h00;

  // ==========================================================
  // successive approximation
  localparam int RES_BITS = 10;
  localparam int RES_LO_W = 2;
  localparam logic [9:0] SAR_MSB = 10'h200;
  localparam logic [3:0] SAR_TOP = 4'h9;
  localparam logic [3:0] STEP_SLOW = 4'h9;
  localparam logic [3:0] STEP_FAST = 4'h5;

  // ==========================================================
  // timing in system-clock states
  localparam logic [7:0] TD_SLOW = 8'h06;
  localparam logic [7:0] TD_FAST = 8'h04;
  localparam logic [7:0] SPL_SLOW = 8'h1f;
  localparam logic [7:0] SPL_FAST = 8'h0f;
  localparam logic [7:0] TOT_SLOW = 8'h83;
  localparam logic [7:0] TOT_FAST = 8'h45;
  localparam logic [7:0] SCAN_SLOW = 8'h80;
  localparam logic [7:0] SCAN_FAST = 8'h42;
  localparam logic [7:0] CONV_SLOW = TOT_SLOW - TD_SLOW - SPL_SLOW;
  localparam logic [7:0] CONV_FAST = TOT_FAST - TD_FAST - SPL_FAST;
  localparam logic [7:0] GAP_SLOW = SCAN_SLOW - SPL_SLOW - CONV_SLOW;
  localparam logic [7:0] GAP_FAST = SCAN_FAST - SPL_FAST - CONV_FAST;

  // ==========================================================
  // types
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_CONV} adcsq_state_e;

  typedef struct packed {
    logic [3:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } adcsq_bus_s;

endpackage
`default_nettype wire

//--- logic/adcsq_trig_sync.sv
`timescale 1ns/1ps
`default_nettype none
module adcsq_trig_sync (
  input wire logic i_sys_clk,  // system clock
  input wire logic i_nrst,     // async reset, active low
  input wire logic i_pin,      // raw trigger pin
  output logic o_fall          // one-cycle falling-edge pulse
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // ==========================================================
  // two-flop synchroniser, edge taken after it
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
      o_fall <= 1'b0;
    end else begin
      meta_r <= i_pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
      o_fall <= prev_r & ~sync_r;
    end
  end

endmodule
`default_nettype wire

//--- logic/adcsq_sar.sv
`timescale 1ns/1ps
`default_nettype none
module adcsq_sar import adcsq_pkg::*; (
  input wire logic i_sys_clk,        // system clock
  input wire logic i_nrst,           // async reset, active low
  input wire logic i_clear,          // synchronous clear
  input wire logic i_load,           // begin a new approximation
  input wire logic [3:0] i_step_len, // states per bit decision
  input wire logic i_cmp,            // 1: input at or above trial
  output logic [9:0] o_code          // trial / final code
);

  logic [3:0] ptr_r;
  logic [3:0] step_r;
  logic busy_r;
  wire step_hit = (step_r == i_step_len - 4'h1);

  // ==========================================================
  // one bit decided per step, msb first
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_code <= '0;
      ptr_r <= '0;
      step_r <= '0;
      busy_r <= 1'b0;
    end else if (i_clear) begin
      o_code <= '0;
      ptr_r <= '0;
      step_r <= '0;
      busy_r <= 1'b0;
    end else if (i_load) begin
      o_code <= SAR_MSB;
      ptr_r <= SAR_TOP;
      step_r <= '0;
      busy_r <= 1'b1;
    end else if (busy_r) begin
      if (step_hit) begin
        step_r <= '0;
        o_code[ptr_r] <= i_cmp;
        if (ptr_r != 4'h0) begin
          o_code[ptr_r - 4'h1] <= 1'b1;
        end else begin
          busy_r <= 1'b0;
        end
        ptr_r <= ptr_r - 4'h1;
      end else begin
        step_r <= step_r + 4'h1;
      end
    end
  end

  a_sar_start: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    i_load && !i_clear |=> o_code == SAR_MSB && busy_r)
    else $error("sar did not start at midscale");

endmodule
`default_nettype wire

//--- logic/adcsq_top.sv
// Overview of operation
// - trigger enable bit 7 gates external and timer starts; 0 ignores them.
// - trigger control register loads 0x7f on reset and standby.
// - trigger control bits 6..1 ignore writes and read as 1.
// - trigger control bit 0 is stored; software must not write 1.
// - reading result upper byte returns it and latches lower byte.
// - reading result lower byte returns the latched byte.
// - 10-bit successive approximation, single and scan modes only.
// - single mode: start bit holds during conversion, cleared at end.
// - single end stores result, sets end flag, clears start, idles.
// - end flag with interrupt enable raises interrupt request.
// - end flag clears by read while set then write of 0.
// - scan starts at group's first channel, next follows at once.
// - scan repeats over selected channels until start is cleared.
// - scan sets end flag after each full cycle and restarts.
// - restart after stopped scan begins at group's first channel.
// - sampling delay is 6..9 states slow, 4..5 states fast.
// - first conversion takes 131..134 or 69..70 states.
// - later scan conversions take 128 or 66 states.
// - external falling edge sets start bit when timer select is clear.
// - result upper 8 bits high byte, low 2 bits at 7..6.
// - group bit picks channels 0-3 or 4-7; low bits pick channel/count.
// - group channels one to four store in registers a to d.
`timescale 1ns/1ps
`default_nettype none
module adcsq_top import adcsq_pkg::*; (
  input wire logic i_sys_clk,        // system clock, 125 MHz
  input wire logic i_nrst,           // async reset, active low
  input wire logic i_standby,        // standby, initialises block
  input wire adcsq_bus_s i_bus,      // cpu byte access
  input wire logic i_ext_trig,       // external trigger pin
  input wire logic i_tmr_match,      // timer compare match pulse
  input wire logic i_tmr_trig_sel,   // timer trigger select
  input wire logic i_cmp,            // analog comparator result
  output logic [7:0] o_rdata,        // read data, one cycle after read
  output logic o_irq,                // end of conversion request
  output logic o_sample,             // sample-and-hold sampling
  output logic [2:0] o_channel,      // analog channel in use
  output logic [9:0] o_dac_code      // trial code to the converter
);

  // ==========================================================
  // state
  adcsq_state_e state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [7:0] csr_r;
  logic [7:0] tcr_r;
  logic start_r;
  logic arm_r;
  logic first_r;
  logic [1:0] idx_r;
  logic [7:0] temp_r;
  logic [9:0] res_r [4];
  logic [7:0] elapsed_r;
  logic ext_fall;

  // ==========================================================
  // decode
  wire wr_csr = i_bus.wr && (i_bus.addr == OFS_CSR);
  wire rd_csr = i_bus.rd && (i_bus.addr == OFS_CSR);
  wire wr_tcr = i_bus.wr && (i_bus.addr == OFS_TCR);
  wire rd_tcr = i_bus.rd && (i_bus.addr == OFS_TCR);
  wire rd_res = i_bus.rd && (i_bus.addr <= OFS_RES_LAST);
  wire rd_hi = !i_bus.addr[OFS_BYTE_LO];
  wire [1:0] rd_idx = i_bus.addr[OFS_IDX_HI:OFS_IDX_LO];
  wire [9:0] rd_word = res_r[rd_idx];
  wire [7:0] res_hi = rd_word[RES_BITS-1:RES_LO_W];
  wire [7:0] res_lo = {rd_word[RES_LO_W-1:0], RES_PAD};

  wire ie_bit = csr_r[CSR_IE];
  wire scan_bit = csr_r[CSR_SCAN];
  wire cks_bit = csr_r[CSR_CKS];
  wire grp_bit = csr_r[CSR_GRP];
  wire [1:0] ch_sel = csr_r[OFS_IDX_LO:0];
  wire [7:0] csr_val = {csr_r[CSR_FLAG:CSR_START+1], start_r, csr_r[CSR_SCAN:0]};
  wire [7:0] tcr_val = tcr_r | TCR_ONES;

  wire [7:0] rdata_nxt = rd_csr ? csr_val :
                         rd_tcr ? tcr_val :
                         rd_res ? (rd_hi ? res_hi : temp_r) :
                         8'h00;

  // ==========================================================
  // start sources
  wire trig_pick = i_tmr_trig_sel ? i_tmr_match : ext_fall;
  wire trig_start = tcr_r[TCR_TE] && trig_pick;

  // ==========================================================
  // timing selection
  wire [7:0] td_len = cks_bit ? TD_FAST : TD_SLOW;
  wire [7:0] spl_len = cks_bit ? SPL_FAST : SPL_SLOW;
  wire [7:0] conv_len = cks_bit ? CONV_FAST : CONV_SLOW;
  wire [7:0] gap_len = cks_bit ? GAP_FAST : GAP_SLOW;
  wire [3:0] step_len = cks_bit ? STEP_FAST : STEP_SLOW;
  wire [7:0] exp_len = first_r ? (cks_bit ? TOT_FAST : TOT_SLOW) :
                                 (cks_bit ? SCAN_FAST : SCAN_SLOW);

  wire conv_end = (state_r == ST_CONV) && (cnt_r == 8'h00) && start_r && !i_standby;
  wire scan_last = (idx_r == ch_sel);
  wire flag_set = conv_end && (!scan_bit || scan_last);
  wire sar_load = (state_r == ST_SAMPLE) && (cnt_r == 8'h00) && start_r;
  wire [1:0] res_idx = scan_bit ? idx_r : ch_sel;
  wire [2:0] cur_ch = {grp_bit, res_idx};
  // fast speed decides the last bit on the store edge itself
  wire [9:0] res_final = cks_bit ? {o_dac_code[RES_BITS-1:1], i_cmp} : o_dac_code;

  wire flag_clr = wr_csr && !i_bus.wdata[CSR_FLAG] && arm_r;
  wire flag_nxt = flag_set ? 1'b1 : (flag_clr ? 1'b0 : csr_r[CSR_FLAG]);
  wire ie_nxt = wr_csr ? i_bus.wdata[CSR_IE] : ie_bit;
  wire start_nxt = trig_start ? 1'b1 :
                   wr_csr ? i_bus.wdata[CSR_START] :
                   (conv_end && !scan_bit) ? 1'b0 :
                   start_r;

  // ==========================================================
  // sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r - 8'h01;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt = cnt_r;
        if (start_r) begin
          state_nxt = ST_DELAY;
          cnt_nxt = td_len - 8'h01;
        end
      end
      ST_DELAY: begin
        if (cnt_r == 8'h00) begin
          state_nxt = ST_SAMPLE;
          cnt_nxt = spl_len - 8'h01;
        end
      end
      ST_SAMPLE: begin
        if (cnt_r == 8'h00) begin
          state_nxt = ST_CONV;
          cnt_nxt = conv_len - 8'h01;
        end
      end
      ST_CONV: begin
        if (cnt_r == 8'h00) begin
          state_nxt = scan_bit ? ST_DELAY : ST_IDLE;
          cnt_nxt = gap_len - 8'h01;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (!start_r || i_standby) begin
      state_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= ST_IDLE;
      cnt_r <= 8'h00;
      o_sample <= 1'b0;
      o_channel <= 3'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      o_sample <= (state_nxt == ST_SAMPLE);
      o_channel <= cur_ch;
    end
  end

  // scan position, always from the group's first channel on a fresh start
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      idx_r <= 2'h0;
      first_r <= 1'b0;
      elapsed_r <= 8'h00;
    end else begin
      if (state_r == ST_IDLE || i_standby) begin
        idx_r <= 2'h0;
      end else if (conv_end && scan_bit) begin
        idx_r <= scan_last ? 2'h0 : idx_r + 2'h1;
      end
      if (state_r == ST_IDLE) begin
        first_r <= 1'b1;
      end else if (conv_end) begin
        first_r <= 1'b0;
      end
      elapsed_r <= (state_r == ST_IDLE || conv_end) ? 8'h01 : elapsed_r + 8'h01;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      csr_r <= CSR_RESET;
      start_r <= 1'b0;
      tcr_r <= TCR_RESET;
      arm_r <= 1'b0;
      o_irq <= 1'b0;
    end else if (i_standby) begin
      csr_r <= CSR_RESET;
      start_r <= 1'b0;
      tcr_r <= TCR_RESET;
      arm_r <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      if (wr_csr) begin
        csr_r[CSR_SCAN:0] <= i_bus.wdata[CSR_SCAN:0];
      end
      csr_r[CSR_FLAG] <= flag_nxt;
      csr_r[CSR_IE] <= ie_nxt;
      start_r <= start_nxt;
      if (wr_tcr) begin
        tcr_r[TCR_TE] <= i_bus.wdata[TCR_TE];
        tcr_r[TCR_RSV] <= i_bus.wdata[TCR_RSV];
      end
      if (rd_csr && csr_r[CSR_FLAG]) begin
        arm_r <= 1'b1;
      end else if (wr_csr) begin
        arm_r <= 1'b0;
      end
      o_irq <= flag_nxt && ie_nxt;
    end
  end

  // results, read latch and read data
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < 4; i++) begin
        res_r[i] <= '0;
      end
      temp_r <= 8'h00;
      o_rdata <= 8'h00;
    end else if (i_standby) begin
      for (int i = 0; i < 4; i++) begin
        res_r[i] <= '0;
      end
      temp_r <= 8'h00;
      o_rdata <= 8'h00;
    end else begin
      if (conv_end) begin
        res_r[res_idx] <= res_final;
      end
      if (rd_res && rd_hi) begin
        temp_r <= res_lo;
      end
      o_rdata <= rdata_nxt;
    end
  end

  // ==========================================================
  // submodules
  adcsq_trig_sync u_sync (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_pin(i_ext_trig),
    .o_fall(ext_fall)
  );

  adcsq_sar u_sar (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_clear(i_standby),
    .i_load(sar_load),
    .i_step_len(step_len),
    .i_cmp(i_cmp),
    .o_code(o_dac_code)
  );

  // ==========================================================
  // checks
  sequence s_flag_armed;
    rd_csr && csr_r[CSR_FLAG] && !i_standby;
  endsequence

  sequence s_gap_cycle;
    !wr_csr && !i_standby;
  endsequence

  sequence s_clear_write;
    wr_csr && !i_bus.wdata[CSR_FLAG] && !flag_set && !i_standby;
  endsequence

  a_tcr_ones: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    rd_tcr && !i_standby |=> o_rdata[6:1] == 6'h3f)
    else $error("reserved control bits not read as one");

  a_trig_gated: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    !tcr_r[TCR_TE] && !wr_csr && !start_r |=> !start_r)
    else $error("start set while triggers disabled");

  a_standby_init: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    i_standby |=> tcr_r == TCR_RESET && !start_r && state_r == ST_IDLE)
    else $error("standby did not initialise control");

  a_irq_raise: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    flag_set && ie_nxt && !i_standby
      |=> o_irq ##1 (o_irq == (csr_r[CSR_FLAG] && csr_r[CSR_IE])))
    else $error("end interrupt not raised");

  a_flag_clear: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    s_flag_armed ##1 s_gap_cycle ##1 s_clear_write |=> !csr_r[CSR_FLAG])
    else $error("end flag not cleared after read then write");

  a_flag_hold: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    csr_r[CSR_FLAG] && !arm_r && !i_standby |=> csr_r[CSR_FLAG])
    else $error("end flag cleared without prior read");

  a_single_end: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    conv_end && !scan_bit && !wr_csr && !trig_start
      |=> !start_r && csr_r[CSR_FLAG] && state_r == ST_IDLE)
    else $error("single conversion end handling wrong");

  a_conv_time: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    conv_end |-> elapsed_r == exp_len)
    else $error("conversion length off");

  a_scan_wrap: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    conv_end && scan_bit && scan_last && !wr_csr |=> idx_r == 2'h0 && state_r == ST_DELAY)
    else $error("scan did not restart at first channel");

  a_temp_latch: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    rd_res && rd_hi && !i_standby |=> temp_r == $past(res_lo) && o_rdata == $past(res_hi))
    else $error("upper byte read did not latch lower byte");

endmodule
`default_nettype wire

//--- verification/adcsq_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcsq_cpu_model import adcsq_pkg::*; (
  input wire logic i_sys_clk,        // system clock
  input wire logic [7:0] i_rdata,    // read data from the block
  input wire logic [2:0] i_channel,  // channel being converted
  input wire logic [9:0] i_dac_code, // trial code
  output var adcsq_bus_s o_bus,      // cpu byte access
  output wire logic o_cmp            // comparator answer
);
  // ==========================================================
  // ideal comparator, one input level per channel
  logic [9:0] vin [8];

  assign o_cmp = vin[i_channel] >= i_dac_code;

  initial begin
    o_bus = '0;
    for (int k = 0; k < 8; k++) begin
      vin[k] = 10'h000;
    end
  end

  // ==========================================================
  // byte accesses, changed only at the falling edge
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    o_bus = '{addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
    @(negedge i_sys_clk);
    o_bus.wr = 1'b0;
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge i_sys_clk);
    o_bus = '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
    @(negedge i_sys_clk);
    d = i_rdata;
    o_bus.rd = 1'b0;
  endtask

  task automatic read_res(input int idx, output logic [15:0] v);
    bus_rd(4'(2 * idx), v[15:8]);
    bus_rd(4'(2 * idx + 1), v[7:0]);
  endtask

  task automatic wr_tcr(input logic [7:0] d);
    bus_wr(OFS_TCR, d & 8'hfe);
  endtask

  task automatic clr_flag(input logic [7:0] keep);
    logic [7:0] d;
    bus_rd(OFS_CSR, d);
    bus_wr(OFS_CSR, keep & 8'h7f);
  endtask

  task automatic restart(input logic [7:0] cfg);
    bus_wr(OFS_CSR, cfg & 8'hdf);
    bus_wr(OFS_CSR, cfg);
  endtask
endmodule
`default_nettype wire

//--- verification/adcsq_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module adcsq_top_tb_top import adcsq_pkg::*; ;
  logic clk = 1'b0;
  logic nrst;
  logic stby;
  logic ext;
  logic tmr;
  logic tsel;
  adcsq_bus_s bus;
  logic cmp;
  logic [7:0] o_rdata;
  logic o_irq;
  logic o_sample;
  logic [2:0] o_channel;
  logic [9:0] o_dac_code;
  int err_count = 0;
  int n_checks = 0;
  int n;
  logic [7:0] v;
  logic [15:0] r;

  always #4 clk = ~clk;

  adcsq_top i_dut (.i_sys_clk(clk), .i_nrst(nrst), .i_standby(stby), .i_bus(bus),
    .i_ext_trig(ext), .i_tmr_match(tmr), .i_tmr_trig_sel(tsel), .i_cmp(cmp),
    .o_rdata(o_rdata), .o_irq(o_irq), .o_sample(o_sample), .o_channel(o_channel),
    .o_dac_code(o_dac_code));

  adcsq_cpu_model i_cpu (.i_sys_clk(clk), .i_rdata(o_rdata), .i_channel(o_channel),
    .i_dac_code(o_dac_code), .o_bus(bus), .o_cmp(cmp));

  // ==========================================================
  // common tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // smp 1: sample window rises, smp 0: request high
  task automatic wait_ev(input logic smp, input int lim, output int cnt);
    logic prev;
    prev = 1'b1;
    for (cnt = 1; cnt <= lim; cnt++) begin
      @(negedge clk);
      if (smp ? (o_sample === 1'b1 && prev === 1'b0) : (o_irq === 1'b1)) begin
        return;
      end
      prev = o_sample;
    end
    err_count++;
    stop_test();
  endtask

  // timer 0: pin falls, timer 1: one match pulse
  task automatic pulse_src(input logic timer);
    @(negedge clk);
    tsel = timer;
    ext = timer;
    tmr = timer;
    @(negedge clk);
    tmr = 1'b0;
    repeat (5) @(negedge clk);
    ext = 1'b1;
    i_cpu.bus_rd(OFS_CSR, v);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    i_cpu.bus_rd(OFS_TCR, v);
    check(v, TCR_RESET);
    i_cpu.bus_rd(OFS_CSR, v);
    check(v, CSR_RESET);
    i_cpu.bus_rd(4'hc, v);
    check(v, 8'h00);
    i_cpu.wr_tcr(8'h80);
    i_cpu.bus_rd(OFS_TCR, v);
    check(v, 8'hfe);
    i_cpu.wr_tcr(8'h00);
    i_cpu.bus_wr(4'h2, 8'hff);
    i_cpu.bus_rd(OFS_TCR, v);
    check(v, 8'h7e);
    i_cpu.read_res(1, r);
    check(r, 16'h0000);
  endtask

  task automatic t_single();
    i_cpu.vin[1] = 10'h2a9;
    i_cpu.bus_wr(OFS_CSR, 8'h69);
    i_cpu.bus_rd(OFS_CSR, v);
    check(v, 8'h69);
    wait_ev(1'b0, 90, n);
    check(n >= 66 && n <= 72, 1'b1);
    check(o_dac_code, 10'h2a9);
    i_cpu.bus_wr(OFS_CSR, 8'h49);
    i_cpu.bus_rd(OFS_CSR, v);
    check(v, 8'hc9);
    i_cpu.clr_flag(8'h49);
    i_cpu.bus_rd(OFS_CSR, v);
    check(v, 8'h49);
    check(o_irq, 1'b0);
    i_cpu.read_res(1, r);
    check(r, 16'haa40);
    i_cpu.bus_rd(4'h2, v);
    i_cpu.bus_rd(4'h1, v);
    check(v, 8'h40);
  endtask

  task automatic t_scan();
    i_cpu.vin[4] = 10'h155;
    i_cpu.vin[5] = 10'h3ff;
    i_cpu.bus_wr(OFS_CSR, 8'h35);
    wait_ev(1'b1, 20, n);
    check(o_channel, 3'h4);
    wait_ev(1'b1, 200, n);
    check(o_channel, 3'h5);
    check(n, 128);
    wait_ev(1'b1, 200, n);
    check(o_channel, 3'h4);
    i_cpu.bus_rd(OFS_CSR, v);
    check(v, 8'hb5);
    i_cpu.read_res(0, r);
    check(r, 16'h5540);
    i_cpu.read_res(1, r);
    check(r, 16'hffc0);
    wait_ev(1'b1, 200, n);
    i_cpu.restart(8'h35);
    wait_ev(1'b1, 20, n);
    check(o_channel, 3'h4);
    i_cpu.clr_flag(8'h15);
    i_cpu.bus_rd(OFS_CSR, v);
    check(v, 8'h15);
    i_cpu.bus_wr(OFS_CSR, 8'h38);
    wait_ev(1'b1, 20, n);
    check(o_channel, 3'h0);
    wait_ev(1'b1, 100, n);
    check(n, 66);
    check(o_channel, 3'h0);
    i_cpu.bus_rd(OFS_CSR, v);
    check(v, 8'hb8);
    i_cpu.clr_flag(8'h18);
    i_cpu.bus_rd(OFS_CSR, v);
    check(v, 8'h18);
  endtask

  task automatic t_trig();
    i_cpu.vin[1] = 10'h0f0;
    i_cpu.bus_wr(OFS_CSR, 8'h09);
    pulse_src(1'b0);
    check(v, 8'h09);
    pulse_src(1'b1);
    check(v, 8'h09);
    i_cpu.wr_tcr(8'h80);
    pulse_src(1'b0);
    check(v, 8'h29);
    repeat (80) @(negedge clk);
    i_cpu.bus_rd(OFS_CSR, v);
    check(v, 8'h89);
    check(o_irq, 1'b0);
    check(o_dac_code, 10'h0f0);
    i_cpu.read_res(1, r);
    check(r, 16'h3c00);
    i_cpu.clr_flag(8'h09);
    pulse_src(1'b1);
    check(v, 8'h29);
    repeat (80) @(negedge clk);
    i_cpu.clr_flag(8'h09);
  endtask

  task automatic t_standby();
    i_cpu.bus_wr(OFS_CSR, 8'h2a);
    @(negedge clk);
    stby = 1'b1;
    repeat (2) @(negedge clk);
    stby = 1'b0;
    i_cpu.bus_rd(OFS_TCR, v);
    check(v, TCR_RESET);
    i_cpu.bus_rd(OFS_CSR, v);
    check(v, CSR_RESET);
    i_cpu.read_res(1, r);
    check(r, 16'h0000);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    stby = 1'b0;
    ext = 1'b1;
    tmr = 1'b0;
    tsel = 1'b0;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_single();
    t_scan();
    t_trig();
    t_standby();
    stop_test();
  end
endmodule
`default_nettype wire
